//--- core/cqa_pkg.sv
// Types of the compare A and output A action block
package cqa_pkg;

   typedef enum logic [1:0] {
      CQA_ACT_NONE,
      CQA_ACT_LOW,
      CQA_ACT_HIGH,
      CQA_ACT_TOGGLE
   } cqa_act_t;

   typedef enum logic [1:0] {
      CQA_LD_ZERO,
      CQA_LD_PERIOD,
      CQA_LD_EITHER,
      CQA_LD_FREEZE
   } cqa_load_t;

   typedef struct packed {
      logic [15:0] a_shadow;
      logic [15:0] a_active;
      logic [7:0] f_shadow;
      logic [7:0] f_active;
      logic direct;
      cqa_load_t load_sel;
      logic pending;
      logic [11:0] action;
      logic pwm;
      logic [31:0] rdata;
   } cqa_state_t;

endpackage : cqa_pkg

//--- core/cqa_regs.svh
// Register offsets, field positions and reset values of the compare A and action block
`ifndef CQA_REGS_SVH
`define CQA_REGS_SVH

`define CQA_OFF_COMBINED 8'h00
`define CQA_OFF_COARSE 8'h04
`define CQA_OFF_FINE 8'h08
`define CQA_OFF_ALIAS 8'h0c
`define CQA_OFF_FINE_ALIAS 8'h10
`define CQA_OFF_CONTROL 8'h14
`define CQA_OFF_ACTION 8'h18

`define CQA_FINE_MSB 15
`define CQA_FINE_LSB 8
`define CQA_COMB_COARSE_MSB 31
`define CQA_COMB_COARSE_LSB 16
`define CQA_CTL_PENDING_BIT 8
`define CQA_CTL_DIRECT_BIT 4
`define CQA_CTL_LOAD_MSB 1
`define CQA_CTL_LOAD_LSB 0
`define CQA_ACT_MSB 11
`define CQA_ACT_FIELDS 6

`define CQA_RST_COARSE 16'h0000
`define CQA_RST_FINE 8'h00
`define CQA_RST_ACTION 12'h000
`define CQA_RST_LOAD 2'h0
`define CQA_RST_DIRECT 1'h0
`define CQA_RST_PENDING 1'h0
`define CQA_RST_PWM 1'h0
`define CQA_RST_RDATA 32'h0000_0000

`endif

//--- core/cqa_top.sv
// Compare A register access paths and output A action qualifier
//
// Operation
// - Fine compare A part sits in bits 15 to 8 of compare_a_fine.
// - Coarse and fine parts are read or written together in one word.
// - Fine part shadowing follows compare_a_direct_mode like the coarse part.
// - Alias reaches the same compare A value but reads back the active value.
// - Shadow mode: alias writes go to shadow, reads active, load on chosen event.
// - Direct mode: shadow bypassed, alias writes go straight to the active value.
// - Fine alias writes behave exactly like fine register writes.
// - Fine alias reads are indeterminate; software must not rely on them.
// - Fine alias writes are shadowed unless direct mode is selected.
// - Bits 11 to 10 act on compare B match while counting down.
// - Bits 9 to 8 act on compare B match while counting up.
// - Bits 7 to 6 act on compare A match while counting down.
// - Bits 5 to 4 act on compare A match while counting up.
// - Bits 3 to 2 act when the counter equals the period.
// - Bits 1 to 0 act when the counter equals zero.
// - Action codes: keep, drive low, drive high, invert.
// - In up-down counting a period match counts as counting down.
// - In up-down counting a zero match counts as counting up.
// - Load select: zero, period, either, or frozen.
// - Pending flag set by combined or coarse writes, not by fine writes.
// - Pending flag clears when the shadow is loaded into the active value.

`include "cqa_regs.svh"

module cqa_top
   import cqa_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [15:0] base_counter,
   input wire logic [15:0] base_period,
   input wire logic count_up,
   input wire logic updown_mode,
   input wire logic [15:0] compare_b_active,
   output logic [15:0] compare_a_active,
   output logic [7:0] compare_a_fine_active,
   output logic pwm_out_a
);

   cqa_state_t s_r;
   cqa_state_t s_nxt;

   logic at_zero;
   logic at_period;
   logic dir_up;
   logic a_match;
   logic b_match;
   logic load_evt;
   logic [5:0] events;
   cqa_act_t act_sel;
   logic wr_coarse;
   logic wr_fine;
   logic [15:0] coarse_val;
   logic [7:0] fine_val;
   logic [31:0] read_val;

   // Next level of the output for one action code
   function automatic logic act_level(input logic lvl, input cqa_act_t act);
      logic res;
      res = lvl;
      unique case (act)
         CQA_ACT_NONE: begin
            res = lvl;
         end
         CQA_ACT_LOW: begin
            res = 1'b0;
         end
         CQA_ACT_HIGH: begin
            res = 1'b1;
         end
         CQA_ACT_TOGGLE: begin
            res = ~lvl;
         end
      endcase
      return res;
   endfunction : act_level

   // Places the fine part in its upper-byte position
   function automatic logic [15:0] fine_word(input logic [7:0] f);
      return {f, 8'h00};
   endfunction : fine_word

   always_comb begin
      s_nxt = s_r;
      wr_coarse = 1'b0;
      wr_fine = 1'b0;
      coarse_val = reg_wdata[15:0];
      fine_val = reg_wdata[`CQA_FINE_MSB:`CQA_FINE_LSB];
      read_val = 32'h0000_0000;
      act_sel = CQA_ACT_NONE;

      // Time-base events
      at_zero = (base_counter == 16'h0000);
      at_period = (base_counter == base_period);
      a_match = (base_counter == s_r.a_active);
      b_match = (base_counter == compare_b_active);
      dir_up = count_up;
      if (updown_mode && at_period) begin
         dir_up = 1'b0;
      end
      if (updown_mode && at_zero) begin
         dir_up = 1'b1;
      end

      // Shadow load strobe
      load_evt = 1'b0;
      unique case (s_r.load_sel)
         CQA_LD_ZERO: begin
            load_evt = at_zero;
         end
         CQA_LD_PERIOD: begin
            load_evt = at_period;
         end
         CQA_LD_EITHER: begin
            load_evt = at_zero | at_period;
         end
         CQA_LD_FREEZE: begin
            load_evt = 1'b0;
         end
      endcase
      if (!s_r.direct && load_evt) begin
         s_nxt.a_active = s_r.a_shadow;
         s_nxt.f_active = s_r.f_shadow;
         s_nxt.pending = 1'b0;
      end

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `CQA_OFF_COMBINED: begin
               coarse_val = reg_wdata[`CQA_COMB_COARSE_MSB:`CQA_COMB_COARSE_LSB];
               wr_coarse = 1'b1;
               wr_fine = 1'b1;
            end
            `CQA_OFF_COARSE: begin
               wr_coarse = 1'b1;
            end
            `CQA_OFF_FINE: begin
               wr_fine = 1'b1;
            end
            `CQA_OFF_ALIAS: begin
               wr_coarse = 1'b1;
            end
            `CQA_OFF_FINE_ALIAS: begin
               wr_fine = 1'b1;
            end
            `CQA_OFF_CONTROL: begin
               s_nxt.direct = reg_wdata[`CQA_CTL_DIRECT_BIT];
               s_nxt.load_sel = cqa_load_t'(reg_wdata[`CQA_CTL_LOAD_MSB:`CQA_CTL_LOAD_LSB]);
            end
            `CQA_OFF_ACTION: begin
               s_nxt.action = reg_wdata[`CQA_ACT_MSB:0];
            end
            default: begin
               s_nxt.action = s_nxt.action;
            end
         endcase
      end

      // Coarse write target; a write in the load cycle wins the flag
      if (wr_coarse) begin
         if (s_r.direct) begin
            s_nxt.a_active = coarse_val;
         end else begin
            s_nxt.a_shadow = coarse_val;
            s_nxt.pending = 1'b1;
         end
      end

      // Fine write target; leaves the flag alone
      if (wr_fine) begin
         if (s_r.direct) begin
            s_nxt.f_active = fine_val;
         end else begin
            s_nxt.f_shadow = fine_val;
         end
      end

      // Register reads, data valid in the following cycle only
      if (reg_rd) begin
         unique case (reg_addr)
            `CQA_OFF_COMBINED: begin
               if (s_r.direct) begin
                  read_val = {s_r.a_active, fine_word(s_r.f_active)};
               end else begin
                  read_val = {s_r.a_shadow, fine_word(s_r.f_shadow)};
               end
            end
            `CQA_OFF_COARSE: begin
               if (s_r.direct) begin
                  read_val = {16'h0000, s_r.a_active};
               end else begin
                  read_val = {16'h0000, s_r.a_shadow};
               end
            end
            `CQA_OFF_FINE: begin
               if (s_r.direct) begin
                  read_val = {16'h0000, fine_word(s_r.f_active)};
               end else begin
                  read_val = {16'h0000, fine_word(s_r.f_shadow)};
               end
            end
            `CQA_OFF_ALIAS: begin
               read_val = {16'h0000, s_r.a_active};
            end
            `CQA_OFF_FINE_ALIAS: begin
               read_val = 32'h0000_0000;
            end
            `CQA_OFF_CONTROL: begin
               read_val[`CQA_CTL_PENDING_BIT] = s_r.pending;
               read_val[`CQA_CTL_DIRECT_BIT] = s_r.direct;
               read_val[`CQA_CTL_LOAD_MSB:`CQA_CTL_LOAD_LSB] = s_r.load_sel;
            end
            `CQA_OFF_ACTION: begin
               read_val = {20'h00000, s_r.action};
            end
            default: begin
               read_val = 32'h0000_0000;
            end
         endcase
      end
      s_nxt.rdata = read_val;

      // Event vector, index i steers action field i
      events[0] = at_zero;
      events[1] = at_period;
      events[2] = a_match & dir_up;
      events[3] = a_match & ~dir_up;
      events[4] = b_match & dir_up;
      events[5] = b_match & ~dir_up;

      // Lowest enabled field wins when events coincide; a disabled field never blocks
      for (int i = `CQA_ACT_FIELDS - 1; i >= 0; i--) begin
         if (events[i] && (s_r.action[2*i +: 2] != 2'h0)) begin
            act_sel = cqa_act_t'(s_r.action[2*i +: 2]);
         end
      end
      s_nxt.pwm = act_level(s_r.pwm, act_sel);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_r.a_shadow <= `CQA_RST_COARSE;
         s_r.a_active <= `CQA_RST_COARSE;
         s_r.f_shadow <= `CQA_RST_FINE;
         s_r.f_active <= `CQA_RST_FINE;
         s_r.direct <= `CQA_RST_DIRECT;
         s_r.load_sel <= CQA_LD_ZERO;
         s_r.pending <= `CQA_RST_PENDING;
         s_r.action <= `CQA_RST_ACTION;
         s_r.pwm <= `CQA_RST_PWM;
         s_r.rdata <= `CQA_RST_RDATA;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign compare_a_active = s_r.a_active;
   assign compare_a_fine_active = s_r.f_active;
   assign pwm_out_a = s_r.pwm;

endmodule : cqa_top

//--- dv/cqa_db_model.sv
// Dead-band stage model counting output A transitions
module cqa_db_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic pwm_in,
   output int edge_cnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic last_r;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         last_r <= 1'h0;
         edge_cnt <= 0;
      end else begin
         last_r <= pwm_in;
         if (pwm_in != last_r) begin
            edge_cnt <= edge_cnt + 1;
         end
      end
   end
endmodule : cqa_db_model

//--- dv/cqa_top_sva.sv
// Port-level checker of the compare A and action block
module cqa_top_sva
   import cqa_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [15:0] base_counter,
   input wire logic [15:0] base_period,
   input wire logic [15:0] compare_a_active,
   input wire logic [7:0] compare_a_fine_active,
   input wire logic pwm_out_a
);
   timeunit 1ns;
   timeprecision 100ps;
   logic dir_r;
   logic [11:0] act_r;
   wire al_wr = reg_wr && reg_addr == 8'h0c;
   wire z = base_counter == 16'h0000;
   // Mirror of mode and action settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dir_r <= 1'h0;
         act_r <= 12'h000;
      end else begin
         if (reg_wr && reg_addr == 8'h14) begin
            dir_r <= reg_wdata[4];
         end
         if (reg_wr && reg_addr == 8'h18) begin
            act_r <= reg_wdata[11:0];
         end
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   zero_high_a: assert property (z && act_r[1:0] == 2'h2 |=> pwm_out_a)
      else $error("output not high after zero");
   zero_low_a: assert property (z && act_r[1:0] == 2'h1 |=> !pwm_out_a)
      else $error("output not low after zero");
   zero_tog_a: assert property (z && act_r[1:0] == 2'h3 |=> pwm_out_a != $past(pwm_out_a))
      else $error("output not inverted");
   act_keep_a: assert property (act_r == 12'h000 |=> $stable(pwm_out_a))
      else $error("output moved with no action");
   direct_wr_a: assert property (dir_r && al_wr |=> compare_a_active == $past(reg_wdata[15:0]))
      else $error("direct write missed");
   shadow_wr_a: assert property (!dir_r && al_wr && !z && base_counter != base_period
      |=> $stable(compare_a_active))
      else $error("shadow write reached active");
   alias_rd_a: assert property (reg_rd && reg_addr == 8'h0c
      |=> reg_rdata == {16'h0000, $past(compare_a_active)})
      else $error("alias read not active");
   fine_dir_a: assert property (dir_r && reg_wr && reg_addr == 8'h10
      |=> compare_a_fine_active == $past(reg_wdata[15:8]))
      else $error("fine alias write missed");
   act_rsvd_a: assert property (reg_rd && reg_addr == 8'h18 |=> reg_rdata[31:12] == 20'h00000)
      else $error("reserved bits not zero");
   cover property (al_wr);
   cover property (reg_rd && reg_addr == 8'h14);
   cover property ($rose(pwm_out_a));
endmodule : cqa_top_sva

//--- dv/cqa_top_tb_top.sv
// Testbench of the compare A and output A action block
module cqa_top_tb_top import cqa_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk, rst, reg_wr, reg_rd, count_up, updown_mode, pwm_out_a, exp_pwm;
   logic [7:0] reg_addr, compare_a_fine_active;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] base_counter, base_period, compare_b_active, compare_a_active, prev_a;
   int error_cnt, tests_run, edge_cnt, exp_edges;
   cqa_top DUT (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .base_counter,
      .base_period, .count_up, .updown_mode, .compare_b_active, .compare_a_active,
      .compare_a_fine_active, .pwm_out_a);
   cqa_db_model u_db (.clk, .rst, .pwm_in(pwm_out_a), .edge_cnt);
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'h0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata, e);
   endtask : rd
   // One cycle of counter value c, then back to a value matching nothing
   task automatic ev(input logic [15:0] c, input logic up);
      @(posedge clk);
      base_counter <= c;
      count_up <= up;
      @(posedge clk);
      base_counter <= 16'h0777;
      #1;
   endtask : ev
   task automatic t_shadow();
      rd(8'h14, 32'h0);
      rd(8'h18, 32'h0);
      wr(8'h04, 32'h1234);
      rd(8'h14, 32'h100);
      rd(8'h0c, 32'h0);
      wr(8'h08, 32'h3400);
      rd(8'h14, 32'h100);
      rd(8'h00, 32'h12343400);
      ev(16'h0, 1'h1);
      chk({8'h00, compare_a_fine_active, compare_a_active}, 32'h341234);
      rd(8'h14, 32'h0);
      $display("shadow test done");
   endtask : t_shadow
   task automatic t_load();
      logic [15:0] v;
      for (int s = 0; s < 4; s++) begin
         v = 16'h1000 + 16'(s);
         wr(8'h14, 32'(s));
         wr(8'h0c, {16'h0000, v});
         wr(8'h10, {16'h0000, v[7:0], 8'h00});
         ev(16'h0100, 1'h1);
         if (s == 1 || s == 2) begin
            prev_a = v;
         end
         chk({8'h00, compare_a_fine_active, compare_a_active}, {8'h00, prev_a[7:0], prev_a});
         ev(16'h0, 1'h1);
         if (s == 0 || s == 2) begin
            prev_a = v;
         end
         chk({8'h00, compare_a_fine_active, compare_a_active}, {8'h00, prev_a[7:0], prev_a});
      end
      $display("load select test done");
   endtask : t_load
   task automatic t_direct();
      wr(8'h14, 32'h10);
      wr(8'h0c, 32'h5555);
      chk({16'h0000, compare_a_active}, 32'h5555);
      wr(8'h10, 32'hcd00);
      chk({24'h000000, compare_a_fine_active}, 32'hcd);
      rd(8'h04, 32'h5555);
      rd(8'h10, 32'h0);
      rd(8'h00, 32'h5555cd00);
      $display("direct test done");
   endtask : t_direct
   task automatic t_act();
      logic [15:0] c [6] = '{16'h0, 16'h0100, 16'h5555, 16'h5555, 16'h0333, 16'h0333};
      logic n;
      for (int i = 0; i < 6; i++) begin
         for (int k = 1; k < 4; k++) begin
            wr(8'h18, 32'hf000 | (32'(k) << (2 * i)));
            rd(8'h18, 32'(k) << (2 * i));
            ev(c[i], i % 2 == 0);
            n = (k == 3) ? !exp_pwm : (k == 2);
            exp_edges += (n != exp_pwm);
            exp_pwm = n;
            chk({31'h0, pwm_out_a}, {31'h0, exp_pwm});
         end
      end
      @(posedge clk);
      #1;
      chk(edge_cnt, exp_edges);
      $display("action test done");
   endtask : t_act
   // Up-down counting: direction forced at period and zero picks the A field
   task automatic t_updown();
      @(posedge clk);
      updown_mode <= 1'h1;
      wr(8'h0c, 32'h0100);
      wr(8'h18, 32'h0080);
      ev(16'h0100, 1'h1);
      exp_edges += 1;
      chk({31'h0, pwm_out_a}, 32'h1);
      wr(8'h0c, 32'h0000);
      wr(8'h18, 32'h0010);
      ev(16'h0000, 1'h0);
      exp_edges += 1;
      chk({31'h0, pwm_out_a}, 32'h0);
      @(posedge clk);
      updown_mode <= 1'h0;
      #1;
      chk(edge_cnt, exp_edges);
      $display("up-down test done");
   endtask : t_updown
   task automatic conclude();
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   initial begin
      {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'h1, 42'h0};
      {base_counter, base_period, compare_b_active} = {16'h0777, 16'h0100, 16'h0333};
      {count_up, updown_mode, exp_pwm, prev_a} = {3'h4, 16'h1234};
      error_cnt = 0;
      tests_run = 0;
      exp_edges = 0;
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      t_shadow();
      t_load();
      t_direct();
      t_act();
      t_updown();
      conclude();
   end
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
endmodule : cqa_top_tb_top

bind cqa_top cqa_top_sva u_sva (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .base_counter, .base_period, .compare_a_active, .compare_a_fine_active, .pwm_out_a);
